// ==== inc/macrocell_params.svh ====
// Constants for the programmable macrocell array
`ifndef MACROCELL_PARAMS_SVH
`define MACROCELL_PARAMS_SVH
`define MC_CELLS      16
`define MC_GROUP      8
`define MC_IN_CELLS   24
`define MC_NIBBLES    6
`define MC_NIB_SIZE   4
`define MC_A_NATIVE   3
`define MC_B_NATIVE   4
`define MC_A_BORROW   6
`define MC_BLO_BORROW 5
`define MC_BHI_BORROW 6
`define MC_MAX_BORROW 6
`define MC_NAT_TOTAL  56
`define MC_B_BASE     24
`define MC_BHI_FIRST  12
`define MC_CLR_TERMS  2
`define MC_MASK_RST   8'h00
`define MC_CELL_RST   16'h0000
`define MC_IC_RST     24'h000000
`define MC_DATA_RST   8'h00
`define MC_SEL_WIDTH  7
`define MC_SEL_OUT_A  0
`define MC_SEL_OUT_B  1
`define MC_SEL_MASK_A 2
`define MC_SEL_MASK_B 3
`define MC_SEL_IN_A   4
`define MC_SEL_IN_B   5
`define MC_SEL_IN_C   6
`define MC_SYNC_W     28
`define MC_SY_CLKPIN  0
`define MC_SY_WR      1
`define MC_SY_RD      2
`define MC_SY_ALS     3
`define MC_SY_PORT    4
`define MC_SYNC_RST   28'h0000006
`endif

// ==== inc/macrocell_pkg.sv ====
// Types for the programmable macrocell array
package macrocell_pkg;
  // Storage element flavour of an output cell
  typedef enum logic [1:0] {ff_d, ff_t, ff_jk, ff_sr} ff_kind_type;
  // Behaviour of an input cell
  typedef enum logic [1:0] {ic_pass, ic_latch, ic_reg, ic_spare} ic_mode_type;
endpackage : macrocell_pkg

// ==== src/programmable_macrocell_array.sv ====
// Output and input macrocells with host load, mask and readback
`timescale 1ns/1ps
`include "macrocell_params.svh"
module programmable_macrocell_array
  import macrocell_pkg::*;
#(
  parameter int CELLS    = `MC_CELLS,
  parameter int IN_CELLS = `MC_IN_CELLS
) (
  input  wire logic                     mclk_i,
  input  wire logic                     rst_n_i,
  // Product terms from the AND array
  input  wire logic [`MC_NAT_TOTAL-1:0] native_pt_i,
  input  wire logic [`MC_NAT_TOTAL-1:0] native_use_i,
  input  wire logic [CELLS*6-1:0]       borrow_req_i,
  input  wire logic [CELLS-1:0]         clock_pt_i,
  input  wire logic [CELLS-1:0]         preset_pt_i,
  input  wire logic [CELLS*2-1:0]       clear_pt_i,
  input  wire logic [CELLS-1:0]         second_pt_i,
  input  wire logic [CELLS-1:0]         enable_pt_i,
  input  wire logic [`MC_NIBBLES-1:0]   in_ctrl_pt_i,
  // Fixed configuration
  input  wire logic [CELLS-1:0]         polarity_i,
  input  wire logic [CELLS*2-1:0]       ff_kind_i,
  input  wire logic [CELLS-1:0]         use_pin_clock_i,
  input  wire logic [CELLS-1:0]         select_comb_i,
  input  wire logic [CELLS-1:0]         internal_node_i,
  input  wire logic [CELLS-1:0]         enable_eq_defined_i,
  input  wire logic [CELLS-1:0]         direction_i,
  input  wire logic [IN_CELLS*2-1:0]    in_mode_i,
  input  wire logic [`MC_NIBBLES-1:0]   in_use_strobe_i,
  // Pins
  input  wire logic                     dedicated_clock_pin_i,
  input  wire logic [IN_CELLS-1:0]      port_pin_i,
  output logic      [CELLS-1:0]         port_pin_o,
  output logic      [CELLS-1:0]         port_pin_oe_o,
  // Host bus
  input  wire logic                     address_latch_strobe_i,
  input  wire logic                     write_strobe_n_i,
  input  wire logic                     read_strobe_n_i,
  input  wire logic [`MC_SEL_WIDTH-1:0] select_i,
  input  wire logic [7:0]               host_data_i,
  output logic      [7:0]               host_data_o,
  output logic                          host_data_oe_o,
  // Logic input bus
  output logic      [CELLS-1:0]         cell_feedback_o,
  output logic      [IN_CELLS-1:0]      input_cell_o
);

  // Native term count of a cell
  function automatic int native_count(input int c);
    native_count = (c < `MC_GROUP) ? `MC_A_NATIVE : `MC_B_NATIVE;
  endfunction : native_count

  // Borrow limit of a cell
  function automatic int borrow_limit(input int c);
    if (c < `MC_GROUP) begin
      borrow_limit = `MC_A_BORROW;
    end else if (c < `MC_BHI_FIRST) begin
      borrow_limit = `MC_BLO_BORROW;
    end else begin
      borrow_limit = `MC_BHI_BORROW;
    end
  endfunction : borrow_limit

  // Flat index of native term j of cell c
  function automatic int term_base(input int c, input int j);
    if (c < `MC_GROUP) begin
      term_base = c * `MC_A_NATIVE + j;
    end else begin
      term_base = `MC_B_BASE + (c - `MC_GROUP) * `MC_B_NATIVE + j;
    end
  endfunction : term_base

  // Source term of borrow slot k: left neighbour first, then right
  function automatic int borrow_src(input int c, input int k);
    int grp;
    int pos;
    int nat;
    grp = (c / `MC_GROUP) * `MC_GROUP;
    pos = c % `MC_GROUP;
    nat = native_count(c);
    if (k < nat) begin
      borrow_src = term_base(grp + (pos + `MC_GROUP - 1) % `MC_GROUP, k);
    end else begin
      borrow_src = term_base(grp + (pos + 1) % `MC_GROUP, k - nat);
    end
  endfunction : borrow_src

  // Synchroniser stages and filtered levels
  logic [`MC_SYNC_W-1:0]    sync1_ff;      // First stage, read by second only
  logic [`MC_SYNC_W-1:0]    sync2_ff;      // Second stage
  logic [`MC_SYNC_W-1:0]    sync3_ff;      // Third stage
  logic [`MC_SYNC_W-1:0]    level_ff;      // Accepted level
  logic [`MC_SYNC_W-1:0]    nxt_level;     // Level once stages agree
  logic [`MC_SYNC_W-1:0]    raw_pins;      // Pins bundled for syncing
  // Output cell state
  logic [CELLS-1:0]         cell_ff;       // Cell flip-flops
  logic [CELLS-1:0]         nxt_cell;      // Next cell state
  logic [CELLS-1:0]         mask_ff;       // Write-block masks, A low
  logic [CELLS-1:0]         nxt_mask;      // Next mask value
  logic [CELLS-1:0]         pt_clock_ff;   // Previous clock term
  // Host write capture and read data
  logic [7:0]               wdata_ff;      // Data held during strobe
  logic [`MC_SEL_WIDTH-1:0] wsel_ff;       // Selects held during strobe
  logic [7:0]               rdata_ff;      // Read data register
  // Input cells
  logic [IN_CELLS-1:0]      in_cell_ff;    // Input cell storage
  logic [IN_CELLS-1:0]      nxt_in_cell;   // Next input cell state
  logic [`MC_NIBBLES-1:0]   in_ctrl_ff;    // Previous nibble control
  logic [`MC_NIBBLES-1:0]   in_ctrl;       // Nibble control selected
  // Combinational terms
  logic [`MC_NAT_TOTAL-1:0] alloc_taken;   // Terms already claimed
  logic [CELLS*6-1:0]       alloc_grant;   // Borrow slots granted
  logic [CELLS-1:0]         term_sum;      // Summed terms per cell
  logic [CELLS-1:0]         comb_result;   // After polarity XOR
  logic [CELLS-1:0]         pin_clk_rise;  // Dedicated clock rising
  logic [CELLS-1:0]         cell_clk_ev;   // Selected clock event
  logic [CELLS-1:0]         host_load;     // Host load this cycle
  logic                     wr_active;     // Write strobe low
  logic                     wr_end;        // Write strobe trailing edge
  logic                     rd_active;     // Read strobe low
  logic                     als_active;    // Address strobe high
  logic [7:0]               read_mux;      // Selected readback byte

  // Bundle the asynchronous pins
  assign raw_pins = {port_pin_i, address_latch_strobe_i, read_strobe_n_i,
                     write_strobe_n_i, dedicated_clock_pin_i};

  // Level changes only once stages two and three agree
  assign nxt_level = (sync2_ff & sync3_ff) | (level_ff & (sync2_ff | sync3_ff));

  // Three-stage pin synchroniser
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_ff <= `MC_SYNC_RST;
      sync2_ff <= `MC_SYNC_RST;
      sync3_ff <= `MC_SYNC_RST;
      level_ff <= `MC_SYNC_RST;
    end else begin
      sync1_ff <= raw_pins;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      level_ff <= nxt_level;
    end
  end

  // Strobe decode from accepted levels
  assign wr_active  = ~level_ff[`MC_SY_WR];
  assign wr_end     = wr_active & nxt_level[`MC_SY_WR];
  assign rd_active  = ~level_ff[`MC_SY_RD];
  assign als_active = level_ff[`MC_SY_ALS];
  assign pin_clk_rise = {CELLS{nxt_level[`MC_SY_CLKPIN] & ~level_ff[`MC_SY_CLKPIN]}};

  // Term allocation across neighbours
  always_comb begin
    int t;
    t = 0;
    alloc_taken = native_use_i;
    alloc_grant = '0;
    term_sum    = '0;
    for (int c = 0; c < CELLS; c++) begin
      for (int j = 0; j < `MC_B_NATIVE; j++) begin
        if (j < native_count(c)) begin
          t = term_base(c, j);
          term_sum[c] = term_sum[c] | (native_use_i[t] & native_pt_i[t]);
        end
      end
      for (int k = 0; k < `MC_MAX_BORROW; k++) begin
        t = borrow_src(c, k);
        if (k < borrow_limit(c) && borrow_req_i[c*6+k] && !alloc_taken[t]) begin
          alloc_grant[c*6+k] = 1'b1;
          alloc_taken[t]     = 1'b1;
          term_sum[c]        = term_sum[c] | native_pt_i[t];
        end
      end
    end
  end

  assign comb_result = term_sum ^ polarity_i;

  // Per-cell logic, one per port pin
  for (genvar c = 0; c < CELLS; c++) begin : g_cell
    ff_kind_type kind;   // Flip-flop flavour
    logic        clr;    // Clear from two terms
    logic        fb;     // Muxed cell result
    assign kind = ff_kind_type'(ff_kind_i[c*2 +: 2]);
    // Clear is OR of two terms
    assign clr  = |clear_pt_i[c*`MC_CLR_TERMS +: `MC_CLR_TERMS];
    assign cell_clk_ev[c] = use_pin_clock_i[c] ? pin_clk_rise[c]
                                               : (clock_pt_i[c] & ~pt_clock_ff[c]);
    assign host_load[c] = wr_end & ~mask_ff[c] &
                          wsel_ff[(c < `MC_GROUP) ? `MC_SEL_OUT_A : `MC_SEL_OUT_B];

    // Next state of the cell flip-flop
    always_comb begin
      nxt_cell[c] = cell_ff[c];
      if (host_load[c]) begin
        nxt_cell[c] = wdata_ff[c % `MC_GROUP];
      end else if (clr) begin
        nxt_cell[c] = 1'b0;
      end else if (preset_pt_i[c]) begin
        nxt_cell[c] = 1'b1;
      end else if (cell_clk_ev[c]) begin
        unique case (kind)
          ff_d:  nxt_cell[c] = comb_result[c];
          ff_t:  nxt_cell[c] = cell_ff[c] ^ comb_result[c];
          ff_jk: nxt_cell[c] = (comb_result[c] & ~cell_ff[c]) |
                               (~second_pt_i[c] & cell_ff[c]);
          ff_sr: nxt_cell[c] = comb_result[c] | (cell_ff[c] & ~second_pt_i[c]);
        endcase
      end
    end

    assign fb = select_comb_i[c] ? comb_result[c] : cell_ff[c];
    assign cell_feedback_o[c] = fb;
    assign port_pin_o[c] = fb & ~internal_node_i[c];
    assign port_pin_oe_o[c] = ~internal_node_i[c] &
                              (enable_pt_i[c] | direction_i[c] | ~enable_eq_defined_i[c]);
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cell_ff     <= `MC_CELL_RST;
      pt_clock_ff <= `MC_CELL_RST;
    end else begin
      cell_ff     <= nxt_cell;
      pt_clock_ff <= clock_pt_i;
    end
  end

  // Mask writes ignore the mask itself
  always_comb begin
    nxt_mask = mask_ff;
    if (wr_end && wsel_ff[`MC_SEL_MASK_A]) begin
      nxt_mask[`MC_GROUP-1:0] = wdata_ff;
    end
    if (wr_end && wsel_ff[`MC_SEL_MASK_B]) begin
      nxt_mask[CELLS-1:`MC_GROUP] = wdata_ff;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_ff <= {`MC_MASK_RST, `MC_MASK_RST};
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wdata_ff <= `MC_DATA_RST;
      wsel_ff  <= '0;
    end else if (wr_active) begin
      wdata_ff <= host_data_i;
      wsel_ff  <= select_i;
    end
  end

  // Nibble control select and input cell update
  for (genvar n = 0; n < `MC_NIBBLES; n++) begin : g_nibble
    assign in_ctrl[n] = in_use_strobe_i[n] ? als_active : in_ctrl_pt_i[n];
    for (genvar b = 0; b < `MC_NIB_SIZE; b++) begin : g_in
      localparam int I = n * `MC_NIB_SIZE + b;
      ic_mode_type mode;   // Input cell behaviour
      logic        pin;    // Accepted pin level
      assign mode = ic_mode_type'(in_mode_i[I*2 +: 2]);
      assign pin  = level_ff[`MC_SY_PORT + I];
      always_comb begin
        nxt_in_cell[I] = in_cell_ff[I];
        unique case (mode)
          ic_latch: nxt_in_cell[I] = in_ctrl[n] ? pin : in_cell_ff[I];
          ic_reg:   nxt_in_cell[I] = (in_ctrl[n] & ~in_ctrl_ff[n]) ? pin
                                                                 : in_cell_ff[I];
          default:  nxt_in_cell[I] = pin;
        endcase
      end
    end
  end

  // Input cell storage
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_cell_ff <= `MC_IC_RST;
      in_ctrl_ff <= '0;
    end else begin
      in_cell_ff <= nxt_in_cell;
      in_ctrl_ff <= in_ctrl;
    end
  end
  assign input_cell_o = in_cell_ff;

  assign read_mux =
      select_i[`MC_SEL_OUT_A]  ? cell_ff[`MC_GROUP-1:0] :
      select_i[`MC_SEL_OUT_B]  ? cell_ff[CELLS-1:`MC_GROUP] :
      select_i[`MC_SEL_MASK_A] ? mask_ff[`MC_GROUP-1:0] :
      select_i[`MC_SEL_MASK_B] ? mask_ff[CELLS-1:`MC_GROUP] :
      select_i[`MC_SEL_IN_A]   ? in_cell_ff[7:0] :
      select_i[`MC_SEL_IN_B]   ? in_cell_ff[15:8] :
      select_i[`MC_SEL_IN_C]   ? in_cell_ff[23:16] : `MC_DATA_RST;

  // Read data register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= `MC_DATA_RST;
    end else begin
      rdata_ff <= read_mux;
    end
  end
  assign host_data_o    = rdata_ff;
  assign host_data_oe_o = rd_active & (|select_i);

endmodule : programmable_macrocell_array

// ==== testbench/programmable_macrocell_array_chk.sv ====
// Port checker for the programmable macrocell array
`timescale 1ns/1ps
module macrocell_chk #(
  parameter int CELLS    = 16,
  parameter int IN_CELLS = 24
) (
  input wire logic               mclk_i,
  input wire logic               rst_n_i,
  input wire logic [CELLS-1:0]   clock_pt_i,
  input wire logic [CELLS-1:0]   preset_pt_i,
  input wire logic [CELLS*2-1:0] clear_pt_i,
  input wire logic [CELLS-1:0]   enable_pt_i,
  input wire logic [CELLS-1:0]   select_comb_i,
  input wire logic [CELLS-1:0]   internal_node_i,
  input wire logic [CELLS-1:0]   enable_eq_defined_i,
  input wire logic [CELLS-1:0]   direction_i,
  input wire logic               dedicated_clock_pin_i,
  input wire logic               write_strobe_n_i,
  input wire logic               read_strobe_n_i,
  input wire logic [CELLS-1:0]   port_pin_o,
  input wire logic [CELLS-1:0]   port_pin_oe_o,
  input wire logic [7:0]         host_data_o,
  input wire logic               host_data_oe_o,
  input wire logic [CELLS-1:0]   cell_feedback_o
);
  // All checks run on the system clock
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Node cells never drive their pins
  node_quiet_a: assert property ((port_pin_oe_o & internal_node_i) == '0)
    else $error("node cell drives its pin");
  // Enable is term OR direction, or always on without an equation
  en_or_a: assert property ((port_pin_oe_o & ~internal_node_i) ==
    (~internal_node_i & (enable_pt_i | direction_i | ~enable_eq_defined_i)))
    else $error("pin enable wrong");
  // Pin and feedback carry the same mux output
  fb_pin_a: assert property (((port_pin_o ^ cell_feedback_o) & ~internal_node_i) == '0)
    else $error("pin and feedback differ");
  // Data bus released while no read strobe
  rd_idle_a: assert property (read_strobe_n_i [*5] |-> !host_data_oe_o)
    else $error("data bus driven without read");
  // Read data cleared while reset is held
  rst_vals_a: assert property (disable iff (1'b0) !rst_n_i |-> host_data_o == 8'h00)
    else $error("read data not cleared in reset");
  // Either clear term wins over preset
  clr_win_a: assert property ((write_strobe_n_i && clear_pt_i[1:0] != 2'h0 &&
    !select_comb_i[0]) [*6] |-> !cell_feedback_o[0]) else $error("clear ignored");
  // Preset alone sets the cell
  preset_set_a: assert property ((write_strobe_n_i && preset_pt_i[0] &&
    clear_pt_i[1:0] == 2'h0 && !select_comb_i[0]) [*6] |-> cell_feedback_o[0])
    else $error("preset ignored");
  // Without writes or internal events the cells hold
  quiet_hold_a: assert property ((write_strobe_n_i && preset_pt_i == '0 &&
    clear_pt_i == '0 && select_comb_i == '0 && $stable(clock_pt_i) &&
    $stable(dedicated_clock_pin_i)) [*7] |-> $stable(cell_feedback_o))
    else $error("cell changed without cause");
  // Main scenarios
  cover property (!write_strobe_n_i ##1 write_strobe_n_i);
  cover property (!read_strobe_n_i && host_data_oe_o);
  cover property ($rose(dedicated_clock_pin_i));
endmodule : macrocell_chk
bind programmable_macrocell_array macrocell_chk #(.CELLS(CELLS), .IN_CELLS(IN_CELLS)) chk (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .clock_pt_i(clock_pt_i), .preset_pt_i(preset_pt_i),
  .clear_pt_i(clear_pt_i), .enable_pt_i(enable_pt_i), .select_comb_i(select_comb_i),
  .internal_node_i(internal_node_i), .enable_eq_defined_i(enable_eq_defined_i),
  .direction_i(direction_i), .dedicated_clock_pin_i(dedicated_clock_pin_i),
  .write_strobe_n_i(write_strobe_n_i), .read_strobe_n_i(read_strobe_n_i),
  .port_pin_o(port_pin_o), .port_pin_oe_o(port_pin_oe_o), .host_data_o(host_data_o),
  .host_data_oe_o(host_data_oe_o), .cell_feedback_o(cell_feedback_o));

// ==== testbench/host_model.sv ====
// Behavioural host microcontroller on the strobe bus
`timescale 1ns/1ps
module host_model (
  input  wire logic       mclk_i,
  input  wire logic [7:0] host_data_o,
  input  wire logic       host_data_oe_o,
  output logic            write_strobe_n_o,
  output logic            read_strobe_n_o,
  output logic            address_latch_strobe_o,
  output logic [6:0]      select_o,
  output logic [7:0]      data_o,
  output logic [7:0]      addr_hi_o
);
  // Idle bus at time zero
  initial begin
    write_strobe_n_o = 1'b1;
    read_strobe_n_o = 1'b1;
    address_latch_strobe_o = 1'b0;
    select_o = 7'h00;
    data_o = 8'h00;
    addr_hi_o = 8'h00;
  end
  // Write: strobe low four cycles, data held past the trailing edge
  task automatic host_write(input int idx, input logic [7:0] d);
    @(negedge mclk_i);
    select_o = 7'h01 << idx;
    data_o = d;
    write_strobe_n_o = 1'b0;
    repeat (4) @(negedge mclk_i);
    write_strobe_n_o = 1'b1;
    repeat (6) @(negedge mclk_i);
    select_o = 7'h00;
    data_o = ~d;
    repeat (3) @(negedge mclk_i);
  endtask : host_write
  // Read: bounded wait for the bus to be driven, unknown if never
  task automatic host_read(input int idx, output logic [7:0] d);
    int n;
    d = 8'hXX;
    @(negedge mclk_i);
    select_o = 7'h01 << idx;
    read_strobe_n_o = 1'b0;
    for (n = 0; n < 10 && host_data_oe_o !== 1'b1; n++) @(negedge mclk_i);
    repeat (2) @(negedge mclk_i);
    if (host_data_oe_o === 1'b1) d = host_data_o;
    read_strobe_n_o = 1'b1;
    select_o = 7'h00;
    repeat (4) @(negedge mclk_i);
  endtask : host_read
  task automatic host_addr(input logic [7:0] a);
    @(negedge mclk_i);
    addr_hi_o = a;
    repeat (4) @(negedge mclk_i);
    address_latch_strobe_o = 1'b1;
    repeat (5) @(negedge mclk_i);
    address_latch_strobe_o = 1'b0;
    repeat (4) @(negedge mclk_i);
    addr_hi_o = ~a;
  endtask : host_addr
endmodule : host_model

// ==== testbench/test_programmable_macrocell_array.sv ====
// Self-checking bench for the programmable macrocell array
`timescale 1ns/1ps
module test_programmable_macrocell_array;
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b1;
  logic [55:0] npt, nuse;
  logic [95:0] brw;
  logic [31:0] clr, kind;
  logic [47:0] imode;
  logic [15:0] ckpt, pre, sec, enpt, pol, upc, comb, node, eqd, dir, pins, pin_o, oe_o, fb;
  logic [5:0]  ictl, istb;
  logic [23:0] ic;
  logic [7:0]  hdo, hdi, ahi;
  logic [6:0]  sel;
  logic        ckpin, hoe, wr_n, rd_n, als;
  int          bad_count = 0;
  int          tests_run = 0;
  int          i;
  // Clock at 50 MHz
  always #10 mclk_i = ~mclk_i;
  // Host bus master
  host_model hm (.mclk_i(mclk_i), .host_data_o(hdo), .host_data_oe_o(hoe),
    .write_strobe_n_o(wr_n), .read_strobe_n_o(rd_n), .address_latch_strobe_o(als),
    .select_o(sel), .data_o(hdi), .addr_hi_o(ahi));
  // Device under test
  programmable_macrocell_array DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .native_pt_i(npt),
    .native_use_i(nuse), .borrow_req_i(brw), .clock_pt_i(ckpt), .preset_pt_i(pre),
    .clear_pt_i(clr), .second_pt_i(sec), .enable_pt_i(enpt), .in_ctrl_pt_i(ictl),
    .polarity_i(pol), .ff_kind_i(kind), .use_pin_clock_i(upc), .select_comb_i(comb),
    .internal_node_i(node), .enable_eq_defined_i(eqd), .direction_i(dir),
    .in_mode_i(imode), .in_use_strobe_i(istb), .dedicated_clock_pin_i(ckpin),
    .port_pin_i({ahi, pins}), .port_pin_o(pin_o), .port_pin_oe_o(oe_o),
    .address_latch_strobe_i(als), .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n),
    .select_i(sel), .host_data_i(hdi), .host_data_o(hdo), .host_data_oe_o(hoe),
    .cell_feedback_o(fb), .input_cell_o(ic));
  // Compare, count, report a mismatch
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : check
  // Read one host location and compare
  task automatic rd_chk(input int idx, input logic [7:0] exp, input string what);
    logic [7:0] d;
    hm.host_read(idx, d);
    check(what, {8'h00, exp}, {8'h00, d});
  endtask : rd_chk
  // One pulse on the dedicated clock pin
  task automatic pulse;
    ckpin = 1'b1;
    repeat (3) @(negedge mclk_i);
    ckpin = 1'b0;
    repeat (6) @(negedge mclk_i);
  endtask : pulse
  // Counts and verdict
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    npt = 56'h0;
    // Cell B0 and cell B1 each use their first native term
    nuse = (56'h1 << 28) | (56'h1 << 24);
    {brw, clr, kind, ckpt, pre, sec, pol, comb, pins, ictl} = '0;
    enpt = 16'h0040;
    upc = 16'h0200;
    node = 16'h0080;
    eqd = 16'hFFF0;
    dir = 16'h0020;
    istb = 6'h30;
    // Input cell 0 uses the spare code, which acts as pass
    imode = 48'hAAAA_5500_0003;
    ckpin = 1'b0;
    // Reset edge after time zero so every flop sees it
    #1 rst_n_i = 1'b0;
    repeat (10) @(negedge mclk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    check("pin enables", 16'h006F, oe_o);
    rd_chk(2, 8'h00, "mask A");
    rd_chk(3, 8'h00, "mask B");
    $display("reset test done");
    hm.host_write(0, 8'h5A);
    rd_chk(0, 8'h5A, "cells A");
    rd_chk(0, 8'h5A, "cells A again");
    hm.host_write(1, 8'hC3);
    rd_chk(1, 8'hC3, "cells B");
    hm.host_write(2, 8'h0F);
    rd_chk(2, 8'h0F, "mask A");
    hm.host_write(0, 8'hF0);
    rd_chk(0, 8'hFA, "masked A");
    hm.host_write(2, 8'h00);
    $display("load and mask test done");
    pre[0] = 1'b1;
    repeat (8) @(negedge mclk_i);
    rd_chk(0, 8'hFB, "preset A0");
    clr[1] = 1'b1;
    repeat (8) @(negedge mclk_i);
    rd_chk(0, 8'hFA, "second clear A0");
    {pre[0], clr[1]} = 2'b00;
    comb[8] = 1'b1;
    for (i = 0; i < 4; i++) begin
      pol[8] = i[0];
      npt[24] = i[1];
      repeat (2) @(negedge mclk_i);
      check("comb pin B0", {15'h0, i[0] ^ i[1]}, {15'h0, pin_o[8]});
      check("comb fb B0", {15'h0, i[0] ^ i[1]}, {15'h0, fb[8]});
    end
    {comb[8], npt[24], pol[8]} = 3'b000;
    // Borrow from the left neighbour of B0
    comb[8] = 1'b1;
    {npt[52], brw[48]} = 2'b11;
    repeat (2) @(negedge mclk_i);
    check("borrow left B0", 16'h0001, {15'h0, pin_o[8]});
    // Right term in use by B1, slot five above the B0 limit
    {npt[52], brw[48]} = 2'b00;
    {npt[28], npt[29], brw[52], brw[53]} = 4'hF;
    repeat (2) @(negedge mclk_i);
    check("borrow refused B0", 16'h0000, {15'h0, pin_o[8]});
    {comb[8], npt[29], brw[52], brw[53]} = 4'h0;
    npt[28] = 1'b1;
    for (i = 0; i < 4; i++) begin
      kind[19:18] = i[1:0];
      hm.host_write(1, 8'h00);
      pulse;
      rd_chk(1, 8'h02, "pin clock set");
      pulse;
      rd_chk(1, (i == 1) ? 8'h00 : 8'h02, "pin clock second");
    end
    $display("cell logic test done");
    pins = 16'h3CA5;
    repeat (6) @(negedge mclk_i);
    rd_chk(4, 8'hA5, "inputs A");
    rd_chk(5, 8'h0C, "inputs B closed");
    ictl[3] = 1'b1;
    repeat (6) @(negedge mclk_i);
    rd_chk(5, 8'h3C, "inputs B open");
    check("input bus AB", 16'h3CA5, ic[15:0]);
    hm.host_addr(8'h96);
    rd_chk(6, 8'h96, "strobe capture C");
    check("input bus C", 16'h0096, {8'h00, ic[23:16]});
    $display("input cell test done");
    end_of_test();
  end
endmodule : test_programmable_macrocell_array
